// ### verilog/iob_io_defines.vh
// Constants for the I/O board input/output logic: register map, fields, reset values, timing.
// Assumes a 125 MHz system clock and a 32-bit APB register bus.
`ifndef IOB_IO_DEFINES_VH
`define IOB_IO_DEFINES_VH

// Board type codes
`define IOB_BOARD_NONE 2'h0
`define IOB_BOARD_MIXED 2'h1
`define IOB_BOARD_SUPERVISION_VARIANT 2'h2

// Timing
`define IOB_CLK_MHZ 125
`define IOB_TICK_US 1000
`define IOB_TICK_CYC (`IOB_CLK_MHZ * `IOB_TICK_US)
`define IOB_TICK_LAST 17'h1_E847
`define IOB_CAN_LED_MS 16'h0032

// Register byte offsets
`define IOB_OFS_BOARD 12'h000
`define IOB_OFS_THRESH 12'h004
`define IOB_OFS_DEBOUNCE 12'h008
`define IOB_OFS_OUTCFG 12'h00C
`define IOB_OFS_OUTCMD 12'h010
`define IOB_OFS_OUTRST 12'h014
`define IOB_OFS_INSTAT 12'h018
`define IOB_OFS_OUTSTAT 12'h01C
`define IOB_OFS_INKIND 12'h020
`define IOB_OFS_SEAL 12'h024
`define IOB_OFS_INDLY 12'h040
`define IOB_OFS_PULSE 12'h080

// Input kinds
`define IOB_IN_POS 2'h0
`define IOB_IN_NEG 2'h1
`define IOB_IN_POSEDGE 2'h2
`define IOB_IN_NEGEDGE 2'h3

// Output kinds
`define IOB_OUT_NORMAL 2'h0
`define IOB_OUT_LATCH 2'h1
`define IOB_OUT_PULSE 2'h2

// Reset values and limits
`define IOB_RST_THRESH 8'h50
`define IOB_RST_DEBOUNCE 6'h0F
`define IOB_RST_DELAY 16'h0000
`define IOB_RST_PULSE 16'h2710
`define IOB_DEBOUNCE_MIN 6'h01
`define IOB_DEBOUNCE_MAX 6'h32
`define IOB_TIME_MAX 16'hEA60
`define IOB_ZERO32 32'h0000_0000

`endif

// ### verilog/iob_io_logic.v
// I/O board input conditioning and contact-output drive, with APB registers.
// Assumes field inputs synchronous to clk; CAN activity arrives as a one-cycle pulse.
//
// Overview of operation
// - Board type register holds 0 none, 1 mixed, 2 supervision.
// - Mixed board conditions sixteen inputs; supervision board eight general inputs.
// - Eight contact outputs are driven for mixed and supervision boards; held low with no board.
// - Two group voltage thresholds, 0 to 255 V, default 80.
// - Changes shorter than group debounce time, 1 to 50 ms, are ignored.
// - Each input has own delay, 0 to 60000 ms, default zero.
// - Level inputs react after debounce time plus input delay.
// - Positive follows filtered level, negative inverts it.
// - Edge kinds fire on debounced transition and skip the delay.
// - Edge signals clear after exactly one scan cycle.
// - Output polarity passes or inverts the activation state.
// - Latched outputs stay active after the command drops.
// - Latched output released only by its reset command.
// - Pulse length used only for pulse outputs, 0 to 60000 ms.
// - Trip outputs 7 and 8 held sealed on the supervision board only, while circuit current exceeds 100 mA.
// - Supervision board takes four voltage detector inputs.
// - Power and CAN activity front indicators are driven.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "iob_io_defines.vh"

module iob_io_logic (
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] rawInputs,
  input wire [3:0] voltDetect,
  input wire [1:0] sealCurrentHigh,
  input wire canActivity,
  output reg [7:0] contactOut,
  output reg ledPower,
  output reg ledCan
);

  // ****************************************
  // Reset release and 1 ms tick
  // ****************************************
  reg rstSync1_q;
  reg rstSync2_q;
  wire rstn = rstSync2_q;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end
    else
    begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  localparam [16:0] TICK_LAST = `IOB_TICK_LAST;
  reg [16:0] tickCnt_q;
  reg tick_q;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tickCnt_q <= 17'h0_0000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (tickCnt_q == TICK_LAST);
      tickCnt_q <= (tickCnt_q == TICK_LAST) ? 17'h0_0000 : tickCnt_q + 17'h0_0001;
    end
  end

  // ****************************************
  // Settings registers
  // ****************************************
  reg [1:0] boardType_q;
  reg [7:0] threshA_q;
  reg [7:0] threshB_q;
  reg [5:0] debA_q;
  reg [5:0] debB_q;
  reg [7:0] outPolarity_q;
  reg [15:0] outKind_q;
  reg [7:0] outCmd_q;
  reg [31:0] inKind_q;
  reg [15:0] inDelay_q [0:15];
  reg [15:0] pulseLen_q [0:7];
  reg [7:0] outRstPulse_q;
  reg [15:0] inLogic_q;
  reg [7:0] outState_q;

  // Misaligned writes are refused, not folded onto an array entry
  wire wrEn = psel & penable & pwrite & (paddr[1:0] == 2'h0);
  wire [15:0] wrTime = (pwdata[15:0] > `IOB_TIME_MAX) ? `IOB_TIME_MAX : pwdata[15:0];
  wire [5:0] debLo = (pwdata[5:0] < `IOB_DEBOUNCE_MIN) ? `IOB_DEBOUNCE_MIN :
    (pwdata[5:0] > `IOB_DEBOUNCE_MAX) ? `IOB_DEBOUNCE_MAX : pwdata[5:0];
  wire [5:0] debHi = (pwdata[21:16] < `IOB_DEBOUNCE_MIN) ? `IOB_DEBOUNCE_MIN :
    (pwdata[21:16] > `IOB_DEBOUNCE_MAX) ? `IOB_DEBOUNCE_MAX : pwdata[21:16];
  // Supervision board only has eight general inputs
  wire [15:0] inMask = (boardType_q == `IOB_BOARD_MIXED) ? 16'hFFFF :
    (boardType_q == `IOB_BOARD_SUPERVISION_VARIANT) ? 16'h00FF : 16'h0000;
  wire [7:0] outMask = (boardType_q == `IOB_BOARD_NONE) ? 8'h00 : 8'hFF;
  wire [3:0] detMask = (boardType_q == `IOB_BOARD_SUPERVISION_VARIANT) ? 4'hF : 4'h0;

  integer k;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      boardType_q <= `IOB_BOARD_NONE;
      threshA_q <= `IOB_RST_THRESH;
      threshB_q <= `IOB_RST_THRESH;
      debA_q <= `IOB_RST_DEBOUNCE;
      debB_q <= `IOB_RST_DEBOUNCE;
      outPolarity_q <= 8'h00;
      outKind_q <= 16'h0000;
      outCmd_q <= 8'h00;
      inKind_q <= 32'h0000_0000;
      outRstPulse_q <= 8'h00;
      for (k = 0; k < 16; k = k + 1)
        inDelay_q[k] <= `IOB_RST_DELAY;
      for (k = 0; k < 8; k = k + 1)
        pulseLen_q[k] <= `IOB_RST_PULSE;
    end
    else
    begin
      outRstPulse_q <= 8'h00;
      if (wrEn)
      begin
        if (paddr == `IOB_OFS_BOARD)
          boardType_q <= (pwdata[1:0] == 2'h3) ? `IOB_BOARD_NONE : pwdata[1:0];
        else if (paddr == `IOB_OFS_THRESH)
        begin
          threshA_q <= pwdata[7:0];
          threshB_q <= pwdata[15:8];
        end
        else if (paddr == `IOB_OFS_DEBOUNCE)
        begin
          debA_q <= debLo;
          debB_q <= debHi;
        end
        else if (paddr == `IOB_OFS_OUTCFG)
        begin
          outPolarity_q <= pwdata[7:0];
          outKind_q <= pwdata[31:16];
        end
        else if (paddr == `IOB_OFS_OUTCMD)
          outCmd_q <= pwdata[7:0];
        else if (paddr == `IOB_OFS_OUTRST)
          outRstPulse_q <= pwdata[7:0];
        else if (paddr == `IOB_OFS_INKIND)
          inKind_q <= pwdata;
        else if (paddr[11:6] == 6'h01)
          inDelay_q[paddr[5:2]] <= wrTime;
        else if (paddr[11:5] == 7'h04)
          pulseLen_q[paddr[4:2]] <= wrTime;
      end
    end
  end

  // ****************************************
  // APB read and answer
  // ****************************************
  reg [31:0] rdMux;
  reg rdErr;
  always @*
  begin
    rdMux = `IOB_ZERO32;
    rdErr = 1'b0;
    if (paddr[1:0] != 2'h0)
      rdErr = 1'b1;
    else if (paddr == `IOB_OFS_BOARD)
      rdMux = {30'h0000_0000, boardType_q};
    else if (paddr == `IOB_OFS_THRESH)
      rdMux = {16'h0000, threshB_q, threshA_q};
    else if (paddr == `IOB_OFS_DEBOUNCE)
      rdMux = {10'h000, debB_q, 10'h000, debA_q};
    else if (paddr == `IOB_OFS_OUTCFG)
      rdMux = {outKind_q, 8'h00, outPolarity_q};
    else if (paddr == `IOB_OFS_OUTCMD)
      rdMux = {24'h00_0000, outCmd_q};
    else if (paddr == `IOB_OFS_OUTRST)
      rdMux = `IOB_ZERO32;
    else if (paddr == `IOB_OFS_INSTAT)
      rdMux = {12'h000, voltDetect & detMask, inLogic_q};
    else if (paddr == `IOB_OFS_OUTSTAT)
      rdMux = {16'h0000, outState_q, contactOut};
    else if (paddr == `IOB_OFS_INKIND)
      rdMux = inKind_q;
    else if (paddr == `IOB_OFS_SEAL)
      rdMux = {30'h0000_0000, sealCurrentHigh};
    else if (paddr[11:6] == 6'h01)
      rdMux = {16'h0000, inDelay_q[paddr[5:2]]};
    else if (paddr[11:5] == 7'h04)
      rdMux = {16'h0000, pulseLen_q[paddr[4:2]]};
    else
      rdErr = 1'b1;
  end

  // Zero-wait answer: pready rises in the first access cycle
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= `IOB_ZERO32;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & rdErr;
      if (psel & ~penable & ~pwrite)
        prdata <= rdMux;
    end
  end

  // ****************************************
  // Input channels
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1)
    begin : gIn
      reg stable_q;
      reg [5:0] debCnt_q;
      reg [15:0] dlyCnt_q;
      reg delayed_q;
      reg edgeHit_q;
      wire [5:0] debSet = (i < 8) ? debA_q : debB_q;
      wire [1:0] kind = inKind_q[2*i+1:2*i];
      wire rawIn = rawInputs[i] & inMask[i];
      wire isEdge = kind[1];
      always @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          stable_q <= 1'b0;
          debCnt_q <= 6'h00;
          dlyCnt_q <= 16'h0000;
          delayed_q <= 1'b0;
          edgeHit_q <= 1'b0;
          inLogic_q[i] <= 1'b0;
        end
        else
        begin
          edgeHit_q <= 1'b0;
          if (rawIn == stable_q)
            debCnt_q <= 6'h00;
          else if (tick_q)
          begin
            if (debCnt_q + 6'h01 >= debSet)
            begin
              stable_q <= rawIn;
              debCnt_q <= 6'h00;
              edgeHit_q <= (kind == `IOB_IN_POSEDGE) ? rawIn : ~rawIn;
            end
            else
              debCnt_q <= debCnt_q + 6'h01;
          end
          // Delay restarts on every new filtered level
          if (stable_q == delayed_q)
            dlyCnt_q <= 16'h0000;
          else if (dlyCnt_q >= inDelay_q[i])
            delayed_q <= stable_q;
          else if (tick_q)
            dlyCnt_q <= dlyCnt_q + 16'h0001;
          if (isEdge)
            inLogic_q[i] <= edgeHit_q;
          else
            inLogic_q[i] <= (kind == `IOB_IN_NEG) ? ~delayed_q : delayed_q;
        end
      end
    end
  endgenerate

  // ****************************************
  // Output channels
  // ****************************************
  genvar j;
  generate
    for (j = 0; j < 8; j = j + 1)
    begin : gOut
      reg cmdPrev_q;
      reg [15:0] pulseCnt_q;
      wire [1:0] kind = outKind_q[2*j+1:2*j];
      // Seal-in only applies to trip contacts 7 and 8
      wire sealed = (j >= 6) && (boardType_q == `IOB_BOARD_SUPERVISION_VARIANT) &&
        sealCurrentHigh[j % 2] && outState_q[j];
      always @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          cmdPrev_q <= 1'b0;
          pulseCnt_q <= 16'h0000;
          outState_q[j] <= 1'b0;
          contactOut[j] <= 1'b0;
        end
        else
        begin
          cmdPrev_q <= outCmd_q[j];
          if (sealed)
            outState_q[j] <= 1'b1;
          else if (kind == `IOB_OUT_LATCH)
          begin
            if (outRstPulse_q[j])
              outState_q[j] <= 1'b0;
            else if (outCmd_q[j])
              outState_q[j] <= 1'b1;
          end
          else if (kind == `IOB_OUT_PULSE)
          begin
            if (outCmd_q[j] & ~cmdPrev_q)
            begin
              outState_q[j] <= (pulseLen_q[j] != 16'h0000);
              pulseCnt_q <= 16'h0000;
            end
            else if (outState_q[j] & tick_q)
            begin
              if (pulseCnt_q + 16'h0001 >= pulseLen_q[j])
                outState_q[j] <= 1'b0;
              pulseCnt_q <= pulseCnt_q + 16'h0001;
            end
          end
          else
            outState_q[j] <= outCmd_q[j];
          contactOut[j] <= outMask[j] & (outState_q[j] ^ outPolarity_q[j]);
        end
      end
    end
  endgenerate

  // ****************************************
  // Front indicators
  // ****************************************
  reg [15:0] canHold_q;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      canHold_q <= 16'h0000;
      ledPower <= 1'b0;
      ledCan <= 1'b0;
    end
    else
    begin
      ledPower <= 1'b1;
      // Stretch so short CAN bursts stay visible
      if (canActivity)
        canHold_q <= `IOB_CAN_LED_MS;
      else if (tick_q && canHold_q != 16'h0000)
        canHold_q <= canHold_q - 16'h0001;
      ledCan <= canActivity | (canHold_q != 16'h0000);
    end
  end

endmodule // iob_io_logic

// ### test/iob_field_model.sv
// Field side model: drives the raw input levels of the board.
// Assumes level changes are requested by the bench after a clock edge.
`timescale 1ns/10ps
module iob_field_model (
  input wire clk,
  input wire [15:0] level,
  input wire glitch,
  output logic [15:0] rawInputs
);
  // ****
  // Short contact bounce
  // ****
  logic [1:0] bounce_q = 2'h0;
  // Three clocks of inversion, far shorter than any debounce time
  always @(posedge clk)
    bounce_q <= glitch ? 2'h3 : bounce_q - {1'b0, bounce_q != 2'h0};
  assign rawInputs = (bounce_q != 2'h0) ? ~level : level;
endmodule // iob_field_model

// ### test/iob_io_logic_sva.sv
// Checker for the board logic, seeing only the top-level ports.
// Assumes one-cycle APB answers and the defines header map.
`timescale 1ns/10ps
`include "iob_io_defines.vh"
module iob_io_logic_sva (
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [15:0] rawInputs,
  input wire [3:0] voltDetect,
  input wire [1:0] sealCurrentHigh,
  input wire canActivity,
  input wire [7:0] contactOut,
  input wire ledPower,
  input wire ledCan
);
  // ****
  // Board type tracking
  // ****
  logic [1:0] board_q;
  logic [2:0] noneCnt_q;
  wire rdAcc = pready && !pwrite;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      board_q <= 2'h0;
      noneCnt_q <= 3'h0;
    end
    else
    begin
      if (psel && penable && pready && pwrite && paddr == `IOB_OFS_BOARD)
        board_q <= (pwdata[1:0] == 2'h3) ? 2'h0 : pwdata[1:0];
      noneCnt_q <= (board_q != 2'h0) ? 3'h0 : noneCnt_q + {2'h0, noneCnt_q != 3'h7};
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  a_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_misalign_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  a_board_code: assert property (rdAcc && paddr == `IOB_OFS_BOARD |->
    !pslverr && prdata[31:2] == 30'h0 && prdata[1:0] != 2'h3)
    else $error("bad board code read");
  a_reset_reads0: assert property (rdAcc && paddr == `IOB_OFS_OUTRST |->
    prdata == 32'h0000_0000)
    else $error("reset command reads nonzero");
  a_power_holds: assert property ($rose(ledPower) |=> ledPower [*8])
    else $error("power indicator dropped");
  a_can_stretch: assert property (canActivity |-> ##[1:2] ledCan ##1 ledCan [*8])
    else $error("activity indicator not stretched");
  a_none_quiet: assert property (noneCnt_q == 3'h7 |-> contactOut == 8'h00)
    else $error("outputs driven with no board");
endmodule // iob_io_logic_sva
bind iob_io_logic iob_io_logic_sva u_sva (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rawInputs(rawInputs), .voltDetect(voltDetect),
  .sealCurrentHigh(sealCurrentHigh), .canActivity(canActivity),
  .contactOut(contactOut), .ledPower(ledPower), .ledCan(ledCan));

// ### test/test_io_board_input_output_logic.sv
// Self-checking bench: APB master, field model, random outputs.
// Assumes the one-cycle APB answer and 2-cycle output update.
`timescale 1ns/10ps
`include "iob_io_defines.vh"
module test_io_board_input_output_logic;
  // ****
  // Signals and helpers
  // ****
  logic clk, resetn, psel, penable, pwrite, canActivity, glitch, lastErr;
  logic pready, pslverr, ledPower, ledCan;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, v;
  logic [15:0] rawInputs, fieldLvl;
  logic [3:0] voltDetect;
  logic [1:0] sealCurrentHigh;
  logic [7:0] contactOut, cmd, pol;
  int fail_count, tests_run;
  int dv[4] = '{0, 1, 50, 63};
  iob_io_logic u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rawInputs(rawInputs), .voltDetect(voltDetect),
    .sealCurrentHigh(sealCurrentHigh), .canActivity(canActivity),
    .contactOut(contactOut), .ledPower(ledPower), .ledCan(ledCan));
  iob_field_model u_field (.clk(clk), .level(fieldLvl), .glitch(glitch),
    .rawInputs(rawInputs));
  function automatic logic [5:0] clampDeb(input int d);
    return d < 1 ? `IOB_DEBOUNCE_MIN : d > 50 ? `IOB_DEBOUNCE_MAX : 6'(d);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do @(posedge clk); while (pready !== 1'b1);
    chk(32'(pready), 1, "no ready");
    rdv = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdv, e, m);
  endtask
  task settle;
    repeat (4) @(posedge clk);
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // Clock, watchdog and tests
  // ****
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #200000;
    fail_count++;
    tally_and_finish;
  end
  initial
  begin
    {resetn, psel, penable, pwrite, canActivity, glitch, sealCurrentHigh} = '0;
    {paddr, pwdata, fieldLvl} = '0;
    fail_count = 0;
    tests_run = 0;
    void'($urandom(32'h52c58f65));
    voltDetect = 4'($urandom);
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rc(`IOB_OFS_THRESH, 32'h0000_5050, "threshold reset");
    rc(`IOB_OFS_DEBOUNCE, 32'h000F_000F, "debounce reset");
    rc(`IOB_OFS_INDLY, 32'h0000_0000, "delay reset");
    rc(`IOB_OFS_PULSE, 32'h0000_2710, "pulse reset");
    chk(32'(ledPower), 1, "power indicator");
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      wr(`IOB_OFS_BOARD, 32'(i));
      rc(`IOB_OFS_BOARD, i == 3 ? 0 : 32'(i), "board code");
    end
    rc(12'hFF0, 32'h0000_0000, "unmapped read");
    chk(32'(lastErr), 1, "unmapped refused");
    rc(12'h002, 32'h0000_0000, "misaligned read");
    chk(32'(lastErr), 1, "misaligned refused");
    for (int k = 0; k < 4; k++)
    begin
      wr(`IOB_OFS_DEBOUNCE, {10'h0, 6'(dv[k]), 10'h0, 6'(dv[3 - k])});
      rc(`IOB_OFS_DEBOUNCE, {10'h0, clampDeb(dv[k]), 10'h0, clampDeb(dv[3 - k])}, "clamp");
    end
    wr(`IOB_OFS_INDLY + 12'h03C, 32'h0000_FFFF);
    rc(`IOB_OFS_INDLY + 12'h03C, {16'h0, `IOB_TIME_MAX}, "delay clamp");
    v = $urandom % 60001;
    wr(`IOB_OFS_PULSE + 12'h01C, v);
    rc(`IOB_OFS_PULSE + 12'h01C, v, "pulse length");
    $display("test registers done");
    wr(`IOB_OFS_OUTCMD, 32'h0000_00FF);
    settle;
    chk(32'(contactOut), 0, "no board outputs");
    wr(`IOB_OFS_BOARD, 32'h0000_0001);
    pol = 8'($urandom);
    wr(`IOB_OFS_OUTCFG, {24'h0, pol});
    repeat (4)
    begin
      cmd = 8'($urandom);
      wr(`IOB_OFS_OUTCMD, {24'h0, cmd});
      settle;
      chk(32'(contactOut), 32'(cmd ^ pol), "normal output");
    end
    $display("test normal outputs done");
    wr(`IOB_OFS_OUTCFG, 32'h5555_0000);
    wr(`IOB_OFS_OUTCMD, 32'h0000_00FF);
    wr(`IOB_OFS_OUTCMD, 32'h0000_0000);
    settle;
    chk(32'(contactOut), 32'h0000_00FF, "latched held");
    wr(`IOB_OFS_OUTRST, 32'h0000_000F);
    settle;
    chk(32'(contactOut), 32'h0000_00F0, "latch release");
    rc(`IOB_OFS_OUTRST, 32'h0000_0000, "reset reads zero");
    wr(`IOB_OFS_PULSE, 32'h0000_0000);
    wr(`IOB_OFS_OUTRST, 32'h0000_00FF);
    wr(`IOB_OFS_OUTCFG, 32'h0002_0000);
    wr(`IOB_OFS_OUTCMD, 32'h0000_0001);
    settle;
    chk(32'(contactOut), 0, "zero length pulse");
    $display("test latch and pulse done");
    glitch <= 1'b1;
    @(posedge clk);
    glitch <= 1'b0;
    repeat (8) @(posedge clk);
    rc(`IOB_OFS_INSTAT, 32'h0000_0000, "bounce and detectors");
    wr(`IOB_OFS_INKIND, 32'h0000_0005);
    rc(`IOB_OFS_INSTAT, 32'h0000_0003, "negative inputs");
    wr(`IOB_OFS_BOARD, 32'h0000_0002);
    rc(`IOB_OFS_INSTAT, {12'h0, voltDetect, 16'h0003}, "detectors");
    wr(`IOB_OFS_OUTCFG, 32'h0000_0000);
    wr(`IOB_OFS_OUTCMD, 32'h0000_0040);
    sealCurrentHigh <= 2'h1;
    wr(`IOB_OFS_OUTCMD, 32'h0000_0000);
    settle;
    chk(32'(contactOut), 32'h0000_0040, "seal held");
    rc(`IOB_OFS_SEAL, 32'h0000_0001, "seal current");
    sealCurrentHigh <= 2'h0;
    settle;
    chk(32'(contactOut), 32'h0000_0000, "seal released");
    canActivity <= 1'b1;
    @(posedge clk);
    canActivity <= 1'b0;
    settle;
    chk(32'(ledCan), 1, "activity indicator");
    $display("test inputs and indicators done");
    tally_and_finish;
  end
endmodule // test_io_board_input_output_logic
